// >>> common/cpu_sfr_pkg.sv
package cpu_sfr_pkg;
    // ==========================================
    // register selects (internal sfr decode)
    localparam logic [3:0] SEL_STACK_UPPER = 4'h0;
    localparam logic [3:0] SEL_STACK_LOWER = 4'h1;
    localparam logic [3:0] SEL_STACK_PTR = 4'h2;
    localparam logic [3:0] SEL_MULDIV_HIGH = 4'h3;
    localparam logic [3:0] SEL_MULDIV_LOW = 4'h4;
    localparam logic [3:0] SEL_MULDIV_CTRL = 4'h5;
    localparam logic [3:0] SEL_CONST_ZERO = 4'h6;
    localparam logic [3:0] SEL_CONST_ONE = 4'h7;
    localparam logic [3:0] SEL_CHIP_ID = 4'h8;
    localparam logic [3:0] SEL_MAKER_ID = 4'h9;
    localparam logic [3:0] SEL_SYS_CONFIG = 4'ha;
    // ==========================================
    // reset values and tied bits
    localparam logic [15:0] STACK_UPPER_RESET = 16'hfc00;
    localparam logic [15:0] STACK_LOWER_RESET = 16'hfa00;
    localparam logic [15:0] STACK_PTR_RESET = 16'hfc00;
    localparam logic [15:0] STACK_TIED_ONES = 16'hf000;
    localparam logic [15:0] STACK_FREE_MASK = 16'h0ffe;
    localparam logic [15:0] MULDIV_CTRL_RESET = 16'h0000;
    localparam logic [15:0] SYS_CONFIG_RESET = 16'h0000;
    localparam int IN_USE_BIT = 4;
    localparam logic [7:0] STATUS_MASK = 8'hef;
    // ==========================================
    // stack pointer operations
    typedef enum logic [2:0] {
        SP_NONE, SP_PUSH, SP_POP, SP_ADD, SP_SUB, SP_MOVE
    } sp_op_e;
    // multiply/divide commands
    typedef enum logic [2:0] {
        MD_IDLE, MD_MUL, MD_MULU, MD_DIVL, MD_DIVLU, MD_DIV, MD_DIVU
    } md_op_e;
    typedef struct packed {
        logic rd;
        logic wr;
        logic [3:0] sel;
        logic [15:0] wdata;
    } sfr_req_s;
    typedef struct packed {
        sp_op_e op;
        logic [15:0] operand;
    } sp_req_s;
endpackage

// >>> src/cpu_stack_limit_muldiv_regs.sv
`timescale 1ns/1ps
// Operation
// [R1] pops and additions to the pointer raise underflow trap when pointer exceeds upper limit
// [R2] upper limit bit0 zero, bits 15..12 one, resets fc00
// [R3] checking applies to add, sub, push, pop, call, return; sp_op_e has no call or return op
// [R4] direct move into the pointer never raises a stack trap
// [R5] rewriting a limit never raises a stack trap by itself
// [R6] multiply leaves high product in high reg, low product in low reg
// [R7] long division takes dividend from high and low registers
// [R8] division leaves remainder in high reg, quotient in low reg
// [R9] in-use flag set by writes to high/low reg and by muldiv commands
// [R10] reading low reg clears in-use flag; high read leaves it
// [R11] control reg: in-use at bit 4, status bits 7..5 and 3..0, upper byte zero
// [R12] control reg updated by hardware every cycle of a muldiv operation
// [R13] software saves and clears control, high, low before reusing unit
// [R14] software sets upper limit to highest bottom-of-stack for caching
// [R15] constant-zero register always reads zero, read-only
// [R16] constant-one register always reads all ones, read-only
// [R17] system config writes ignored after end-of-init instruction
// [R18] identification registers are read-only
// [R19] chip identity: device code upper byte, revision lower byte
// [R20] maker identity returns a fixed maker code
// [R21] pushes and subtractions raise overflow trap when pointer below lower limit
// [R22] writes to constant, identity and tied bits have no effect
module cpu_stack_limit_muldiv_regs
    import cpu_sfr_pkg::*;
#(
    parameter logic [7:0] DEVICE_CODE = 8'h5a,   // arbitrary value
    parameter logic [7:0] REVISION_CODE = 8'h03, // arbitrary value
    parameter logic [15:0] MAKER_CODE = 16'h0123, // arbitrary value
    parameter int DIV_CYCLES = 16
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // sfr access
    input wire cpu_sfr_pkg::sfr_req_s sfr_req,
    output logic [15:0] sfr_rdata,
    // stack pointer operations
    input wire cpu_sfr_pkg::sp_req_s sp_req,
    output logic [15:0] stack_top_pointer,
    output logic underflow_trap,
    output logic overflow_trap,
    // multiply/divide
    input wire cpu_sfr_pkg::md_op_e md_cmd,
    input wire logic [15:0] md_operand,
    output logic md_busy,
    output logic md_div_zero,
    // init
    input wire logic end_of_init_instr,
    output logic [15:0] system_config
);
    import cpu_sfr_pkg::*;

    initial begin
        if (DIV_CYCLES != 16) $error("DIV_CYCLES must be 16");
    end

    // ==========================================
    // state
    logic [15:0] upper_q, upper_d, lower_q, lower_d, sp_q, sp_d;
    logic uf_q, uf_d, of_q, of_d;
    logic [31:0] md_q, md_d;
    logic [7:0] mdc_q, mdc_d;
    logic [15:0] sysc_q, sysc_d;
    logic init_done_q, init_done_d;
    logic [15:0] rdata_q, rdata_d;
    logic busy_q, busy_d, dz_q, dz_d;
    logic [15:0] divisor_q, divisor_d;
    logic div_signed_q, div_signed_d, div_long_q, div_long_d;
    // quotient sign is kept apart, the work register only ever holds magnitudes
    logic quo_neg_q, quo_neg_d;
    logic [4:0] cnt_q, cnt_d;
    logic [31:0] work, product;
    logic [16:0] trial;
    logic [15:0] new_sp;
    logic [15:0] abs_div, abs_num_hi, abs_num_lo;
    logic num_neg;

    wire sel_wr = sfr_req.wr;
    wire [15:0] wdat = sfr_req.wdata;

    function automatic logic [15:0] stack_fix(input logic [15:0] v);
        stack_fix = (v & STACK_FREE_MASK) | STACK_TIED_ONES; // R2
    endfunction

    // ==========================================
    // stack pointer and limit checking
    always_comb begin
        upper_d = upper_q;
        lower_d = lower_q;
        sp_d = sp_q;
        uf_d = 1'b0;
        of_d = 1'b0;
        new_sp = sp_q;
        if (sel_wr && sfr_req.sel == SEL_STACK_UPPER) upper_d = stack_fix(wdat); // R2 R5 R22
        if (sel_wr && sfr_req.sel == SEL_STACK_LOWER) lower_d = stack_fix(wdat); // R5
        if (sel_wr && sfr_req.sel == SEL_STACK_PTR) sp_d = stack_fix(wdat); // R4
        case (sp_req.op)
            SP_PUSH: new_sp = stack_fix(sp_q - 16'h0002);
            SP_POP: new_sp = stack_fix(sp_q + 16'h0002);
            SP_ADD: new_sp = stack_fix(sp_q + sp_req.operand);
            SP_SUB: new_sp = stack_fix(sp_q - sp_req.operand);
            SP_MOVE: new_sp = stack_fix(sp_req.operand);
            default: new_sp = sp_q;
        endcase
        if (sp_req.op != SP_NONE) sp_d = new_sp; // R3
        if ((sp_req.op == SP_POP || sp_req.op == SP_ADD) && new_sp > upper_q) uf_d = 1'b1; // R1 R3
        if ((sp_req.op == SP_PUSH || sp_req.op == SP_SUB) && new_sp < lower_q) of_d = 1'b1; // R21
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            upper_q <= STACK_UPPER_RESET;
            lower_q <= STACK_LOWER_RESET;
            sp_q <= STACK_PTR_RESET;
            uf_q <= 1'b0;
            of_q <= 1'b0;
        end else begin
            upper_q <= upper_d;
            lower_q <= lower_d;
            sp_q <= sp_d;
            uf_q <= uf_d;
            of_q <= of_d;
        end
    end

    // ==========================================
    // multiply/divide unit; restoring division, one bit per cycle
    always_comb begin
        md_d = md_q;
        mdc_d = mdc_q;
        busy_d = busy_q;
        dz_d = 1'b0;
        divisor_d = divisor_q;
        div_signed_d = div_signed_q;
        div_long_d = div_long_q;
        quo_neg_d = quo_neg_q;
        cnt_d = cnt_q;
        work = md_q;
        trial = 17'h00000;
        product = 32'h00000000;
        num_neg = 1'b0;
        abs_div = md_operand[15] ? 16'(-md_operand) : md_operand;
        abs_num_hi = md_q[31:16];
        abs_num_lo = md_q[15:0];
        if (busy_q) begin
            trial = {work[31:15]} - {1'b0, divisor_q};
            work = {work[30:0], 1'b0};
            if (!trial[16]) begin
                work[31:16] = trial[15:0];
                work[0] = 1'b1;
            end
            md_d = work;
            cnt_d = 5'(cnt_q - 5'h01);
            mdc_d = {3'(cnt_d[2:0]), 1'b1, cnt_d[3:0]}; // R12
            if (cnt_q == 5'h01) begin
                busy_d = 1'b0;
                mdc_d[7:5] = 3'h0;
                mdc_d[3:0] = 4'h0;
                // signed fixup on quotient (low) only; remainder (high) keeps its magnitude
                if (div_signed_q && quo_neg_q) md_d[15:0] = 16'(-work[15:0]); // R8
                if (div_signed_q && div_long_q) md_d[31:16] = work[31:16];
            end
        end else begin
            case (md_cmd)
                MD_MUL: begin
                    product = 32'($signed(md_q[15:0]) * $signed(md_operand));
                    md_d = product; // R6
                    mdc_d[IN_USE_BIT] = 1'b1; // R9
                end
                MD_MULU: begin
                    product = md_q[15:0] * md_operand;
                    md_d = product; // R6
                    mdc_d[IN_USE_BIT] = 1'b1; // R9
                end
                MD_DIV, MD_DIVU, MD_DIVL, MD_DIVLU: begin
                    mdc_d[IN_USE_BIT] = 1'b1; // R9
                    if (md_operand == 16'h0000) begin
                        dz_d = 1'b1;
                    end else begin
                        div_signed_d = (md_cmd == MD_DIV || md_cmd == MD_DIVL);
                        div_long_d = (md_cmd == MD_DIVL || md_cmd == MD_DIVLU);
                        // 16-bit forms divide the low register alone
                        if (md_cmd == MD_DIV || md_cmd == MD_DIVU) abs_num_hi = div_signed_d ? {16{md_q[15]}} : 16'h0000;
                        num_neg = div_signed_d && (div_long_d ? md_q[31] : md_q[15]);
                        if (div_signed_d && num_neg) {abs_num_hi, abs_num_lo} = 32'(-{abs_num_hi, abs_num_lo});
                        // high half must stay below the divisor or the quotient overflows 16 bits
                        md_d = {abs_num_hi, abs_num_lo}; // R7
                        quo_neg_d = num_neg ^ (div_signed_d && md_operand[15]);
                        divisor_d = div_signed_d ? abs_div : md_operand;
                        cnt_d = 5'h10;
                        busy_d = 1'b1;
                        mdc_d = {3'h7, 1'b1, 4'hf}; // R12
                    end
                end
                default: ;
            endcase
            if (sel_wr && sfr_req.sel == SEL_MULDIV_CTRL) mdc_d = wdat[7:0] & (STATUS_MASK | 8'h10);
            if (sel_wr && sfr_req.sel == SEL_MULDIV_HIGH) begin
                md_d[31:16] = wdat;
                mdc_d[IN_USE_BIT] = 1'b1; // R9
            end
            if (sel_wr && sfr_req.sel == SEL_MULDIV_LOW) begin
                md_d[15:0] = wdat;
                mdc_d[IN_USE_BIT] = 1'b1; // R9
            end
            // a same-cycle set beats the read clear
            if (sfr_req.rd && sfr_req.sel == SEL_MULDIV_LOW && md_cmd == MD_IDLE
                && !(sel_wr && (sfr_req.sel == SEL_MULDIV_LOW))) mdc_d[IN_USE_BIT] = 1'b0; // R10
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            md_q <= 32'h00000000;
            mdc_q <= MULDIV_CTRL_RESET[7:0];
            busy_q <= 1'b0;
            dz_q <= 1'b0;
            divisor_q <= 16'h0001;
            div_signed_q <= 1'b0;
            div_long_q <= 1'b0;
            quo_neg_q <= 1'b0;
            cnt_q <= 5'h00;
        end else begin
            md_q <= md_d;
            mdc_q <= mdc_d;
            busy_q <= busy_d;
            dz_q <= dz_d;
            divisor_q <= divisor_d;
            div_signed_q <= div_signed_d;
            div_long_q <= div_long_d;
            quo_neg_q <= quo_neg_d;
            cnt_q <= cnt_d;
        end
    end

    // ==========================================
    // system config lock and read data
    always_comb begin
        sysc_d = sysc_q;
        init_done_d = init_done_q | end_of_init_instr;
        if (sel_wr && sfr_req.sel == SEL_SYS_CONFIG && !init_done_q) sysc_d = wdat; // R17
        case (sfr_req.sel)
            SEL_STACK_UPPER: rdata_d = upper_q;
            SEL_STACK_LOWER: rdata_d = lower_q;
            SEL_STACK_PTR: rdata_d = sp_q;
            SEL_MULDIV_HIGH: rdata_d = md_q[31:16];
            SEL_MULDIV_LOW: rdata_d = md_q[15:0];
            SEL_MULDIV_CTRL: rdata_d = {8'h00, mdc_q}; // R11
            SEL_CONST_ZERO: rdata_d = 16'h0000; // R15 R22
            SEL_CONST_ONE: rdata_d = 16'hffff; // R16 R22
            SEL_CHIP_ID: rdata_d = {DEVICE_CODE, REVISION_CODE}; // R18 R19
            SEL_MAKER_ID: rdata_d = MAKER_CODE; // R20
            SEL_SYS_CONFIG: rdata_d = sysc_q;
            default: rdata_d = 16'h0000;
        endcase
        if (!sfr_req.rd) rdata_d = 16'h0000;
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sysc_q <= SYS_CONFIG_RESET;
            init_done_q <= 1'b0;
            rdata_q <= 16'h0000;
        end else begin
            sysc_q <= sysc_d;
            init_done_q <= init_done_d;
            rdata_q <= rdata_d;
        end
    end

    assign sfr_rdata = rdata_q;
    assign stack_top_pointer = sp_q;
    assign underflow_trap = uf_q;
    assign overflow_trap = of_q;
    assign md_busy = busy_q;
    assign md_div_zero = dz_q;
    assign system_config = sysc_q;

    // ==========================================
    // checks
    a_upper_tied_bits: assert property (@(posedge core_clk) disable iff (sys_rst) // R2
        upper_q[15:12] == 4'hf && upper_q[0] == 1'b0) else $error("upper limit tied bits broken");
    a_pop_underflow: assert property (@(posedge core_clk) disable iff (sys_rst) // R1
        (sp_req.op == SP_POP && stack_fix(sp_q + 16'h0002) > upper_q) |=> underflow_trap)
        else $error("pop past upper limit gave no trap");
    a_move_no_trap: assert property (@(posedge core_clk) disable iff (sys_rst) // R4
        (sp_req.op == SP_MOVE) |=> !underflow_trap && !overflow_trap) else $error("move raised a trap");
    a_limit_no_trap: assert property (@(posedge core_clk) disable iff (sys_rst) // R5
        (sp_req.op == SP_NONE) |=> !underflow_trap && !overflow_trap) else $error("trap without stack op");
    a_push_overflow: assert property (@(posedge core_clk) disable iff (sys_rst) // R21
        (sp_req.op == SP_PUSH && stack_fix(sp_q - 16'h0002) < lower_q) |=> overflow_trap)
        else $error("push below lower limit gave no trap");
    a_mulu_result: assert property (@(posedge core_clk) disable iff (sys_rst) // R6
        (!busy_q && md_cmd == MD_MULU) |=> md_q == $past(md_q[15:0]) * $past(md_operand))
        else $error("unsigned product wrong");
    a_write_sets_use: assert property (@(posedge core_clk) disable iff (sys_rst) // R9
        (!busy_q && sel_wr && sfr_req.sel == SEL_MULDIV_HIGH) |=> mdc_q[IN_USE_BIT])
        else $error("in-use flag not set");
    a_read_clears_use: assert property (@(posedge core_clk) disable iff (sys_rst) // R10
        (!busy_q && sfr_req.rd && !sel_wr && sfr_req.sel == SEL_MULDIV_LOW && md_cmd == MD_IDLE)
        |=> !mdc_q[IN_USE_BIT]) else $error("low read did not clear in-use");
    a_div_length: assert property (@(posedge core_clk) disable iff (sys_rst) // R12
        $rose(busy_q) |-> busy_q [*8] ##1 busy_q [*8] ##1 !busy_q) else $error("division took wrong cycle count");
    a_high_read_keeps: assert property (@(posedge core_clk) disable iff (sys_rst) // R10
        (!busy_q && sfr_req.rd && !sel_wr && sfr_req.sel == SEL_MULDIV_HIGH && md_cmd == MD_IDLE)
        |=> mdc_q[IN_USE_BIT] == $past(mdc_q[IN_USE_BIT])) else $error("high read changed in-use");
    a_ones_reads: assert property (@(posedge core_clk) disable iff (sys_rst) // R16
        (sfr_req.rd && sfr_req.sel == SEL_CONST_ONE) |=> sfr_rdata == 16'hffff)
        else $error("constant-one read wrong");
    a_div_zero_flag: assert property (@(posedge core_clk) disable iff (sys_rst) // R12
        (!busy_q && md_operand == 16'h0000 && (md_cmd == MD_DIVU || md_cmd == MD_DIV))
        |=> md_div_zero && !md_busy) else $error("divide by zero not flagged");
    a_config_locked: assert property (@(posedge core_clk) disable iff (sys_rst) // R17
        init_done_q |=> $stable(sysc_q)) else $error("config changed after init end");
endmodule

// >>> verif/cpu_stack_limit_muldiv_regs_tb.sv
`timescale 1ns/1ps
module cpu_stack_limit_muldiv_regs_tb;
    import cpu_sfr_pkg::*;
    // ==========================================
    // identity values are arbitrary
    localparam logic [7:0] DC = 8'h3c;
    localparam logic [7:0] RC = 8'h02;
    localparam logic [15:0] MC = 16'h0abc;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    sfr_req_s sfr_req = '0;
    logic [15:0] sfr_rdata;
    sp_req_s sp_req = '{op: SP_NONE, operand: 16'h0000};
    logic [15:0] stack_top_pointer;
    logic underflow_trap;
    logic overflow_trap;
    md_op_e md_cmd = MD_IDLE;
    logic [15:0] md_operand = 16'h0000;
    logic md_busy;
    logic md_div_zero;
    logic end_of_init_instr = 1'b0;
    logic [15:0] system_config;
    int err_count = 0;
    int checks = 0;
    integer seed = 32'h0d1873f0;
    int k;
    logic [15:0] ptr_x = 16'hfc00;
    logic [15:0] upper_x = 16'hfc00;
    logic [15:0] lower_x = 16'hfa00;
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] h;
    logic [3:0] csel [4] = '{SEL_CONST_ZERO, SEL_CONST_ONE, SEL_CHIP_ID, SEL_MAKER_ID};
    logic [15:0] cval [4] = '{16'h0000, 16'hffff, {DC, RC}, MC};
    md_op_e ops [6] = '{MD_MUL, MD_MULU, MD_DIVL, MD_DIVLU, MD_DIV, MD_DIVU};
    cpu_stack_limit_muldiv_regs #(.DEVICE_CODE(DC), .REVISION_CODE(RC), .MAKER_CODE(MC), .DIV_CYCLES(16)) dut (
        .core_clk(core_clk), .sys_rst(sys_rst), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .sp_req(sp_req),
        .stack_top_pointer(stack_top_pointer), .underflow_trap(underflow_trap), .overflow_trap(overflow_trap),
        .md_cmd(md_cmd), .md_operand(md_operand), .md_busy(md_busy), .md_div_zero(md_div_zero),
        .end_of_init_instr(end_of_init_instr), .system_config(system_config));
    initial begin
        forever #4 core_clk = ~core_clk;
    end
    // ==========================================
    // shared tasks
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
            err_count++;
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [3:0] sel, input logic [15:0] d);
        @(posedge core_clk);
        sfr_req <= '{rd: 1'b0, wr: 1'b1, sel: sel, wdata: d};
        @(posedge core_clk);
        sfr_req <= '0;
    endtask
    // read data is registered, so it is sampled once the following edge has landed
    task automatic rchk(input string name, input logic [3:0] sel, input logic [15:0] exp, input logic [15:0] m);
        @(posedge core_clk);
        sfr_req <= '{rd: 1'b1, wr: 1'b0, sel: sel, wdata: 16'h0000};
        @(posedge core_clk);
        sfr_req <= '0;
        @(negedge core_clk);
        chk(name, exp & m, sfr_rdata & m);
    endtask
    task automatic sp(input sp_op_e op, input logic [15:0] v);
        logic [15:0] n;
        logic uf;
        logic of;
        case (op)
            SP_PUSH: n = ptr_x - 16'h0002;
            SP_POP: n = ptr_x + 16'h0002;
            SP_ADD: n = ptr_x + v;
            SP_SUB: n = ptr_x - v;
            default: n = v;
        endcase
        n = (n & 16'h0ffe) | 16'hf000;
        uf = (op == SP_POP || op == SP_ADD) && n > upper_x;
        of = (op == SP_PUSH || op == SP_SUB) && n < lower_x;
        ptr_x = n;
        @(posedge core_clk);
        sp_req <= '{op: op, operand: v};
        @(posedge core_clk);
        sp_req <= '{op: SP_NONE, operand: 16'h0000};
        @(negedge core_clk);
        chk("pointer", n, stack_top_pointer);
        chk("underflow_trap", {15'h0000, uf}, {15'h0000, underflow_trap});
        chk("overflow_trap", {15'h0000, of}, {15'h0000, overflow_trap});
    endtask
    // multiplicand sits in the low register; operand is multiplier or divisor
    task automatic md(input md_op_e op, input logic [15:0] hi, input logic [15:0] lo, input logic [15:0] dv);
        logic [31:0] num;
        logic [31:0] q;
        logic [31:0] r;
        logic [31:0] e;
        int i;
        num = (op == MD_DIVL || op == MD_DIVLU) ? {hi, lo} : {16'h0000, lo};
        q = num / {16'h0000, dv};
        r = num % {16'h0000, dv};
        e = (op == MD_MUL || op == MD_MULU) ? {16'h0000, lo} * {16'h0000, dv} : {r[15:0], q[15:0]};
        wr(SEL_MULDIV_HIGH, hi);
        wr(SEL_MULDIV_LOW, lo);
        rchk("in_use_after_write", SEL_MULDIV_CTRL, 16'h0010, 16'hff10);
        @(posedge core_clk);
        md_cmd <= op;
        md_operand <= dv;
        @(posedge core_clk);
        md_cmd <= MD_IDLE;
        @(negedge core_clk);
        for (i = 0; i < 40 && md_busy !== 1'b0; i++) begin
            @(negedge core_clk);
        end
        if (i == 40) begin
            $display("MISMATCH md_busy expected 0 seen 1");
            err_count++;
            tally_and_finish();
        end
        rchk("high_result", SEL_MULDIV_HIGH, e[31:16], 16'hffff);
        rchk("in_use_after_high_read", SEL_MULDIV_CTRL, 16'h0010, 16'hff10);
        rchk("low_result", SEL_MULDIV_LOW, e[15:0], 16'hffff);
        rchk("in_use_after_low_read", SEL_MULDIV_CTRL, 16'h0000, 16'hff10);
    endtask
    // ==========================================
    // watchdog
    initial begin
        repeat (100000) @(posedge core_clk);
        $display("MISMATCH run_length expected end seen hang");
        err_count++;
        tally_and_finish();
    end
    // ==========================================
    // main sequence
    initial begin
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        rchk("upper_reset", SEL_STACK_UPPER, 16'hfc00, 16'hffff);
        rchk("lower_reset", SEL_STACK_LOWER, 16'hfa00, 16'hffff);
        rchk("control_reset", SEL_MULDIV_CTRL, 16'h0000, 16'hffff);
        chk("pointer_reset", 16'hfc00, stack_top_pointer);
        for (k = 0; k < 4; k++) begin
            wr(csel[k], ~cval[k]);
            rchk("constant_or_identity", csel[k], cval[k], 16'hffff);
        end
        $display("test registers done");
        sp(SP_POP, 16'h0000);
        sp(SP_MOVE, 16'hfe00);
        sp(SP_MOVE, 16'hfc00);
        sp(SP_ADD, 16'h0004);
        sp(SP_SUB, 16'h0008);
        sp(SP_PUSH, 16'h0000);
        sp(SP_SUB, 16'h0200);
        sp(SP_PUSH, 16'h0000);
        sp(SP_POP, 16'h0000);
        // both limits now exclude the pointer, yet no trap may follow
        wr(SEL_STACK_UPPER, 16'h0001);
        wr(SEL_STACK_LOWER, 16'hfc00);
        repeat (3) begin
            @(negedge core_clk);
            chk("underflow_after_limit_write", 16'h0000, {15'h0000, underflow_trap});
            chk("overflow_after_limit_write", 16'h0000, {15'h0000, overflow_trap});
        end
        rchk("upper_tied_bits", SEL_STACK_UPPER, 16'hf000, 16'hffff);
        upper_x = 16'hf000;
        lower_x = 16'hfc00;
        sp(SP_POP, 16'h0000);
        $display("test stack done");
        md(MD_MULU, 16'h0000, 16'hffff, 16'hffff);
        md(MD_DIVLU, 16'h00fe, 16'hffff, 16'h00ff);
        // signed corner: magnitudes divided, quotient takes the sign
        wr(SEL_MULDIV_CTRL, 16'h0000);
        wr(SEL_MULDIV_HIGH, 16'h0000);
        wr(SEL_MULDIV_LOW, 16'hfff0);
        @(posedge core_clk);
        md_cmd <= MD_DIV;
        md_operand <= 16'h0003;
        @(posedge core_clk);
        md_cmd <= MD_IDLE;
        @(negedge core_clk);
        for (k = 0; k < 40 && md_busy !== 1'b0; k++) begin
            @(negedge core_clk);
        end
        chk("signed_div_done", 16'h0000, {15'h0000, md_busy});
        if (k == 40) tally_and_finish();
        rchk("signed_remainder", SEL_MULDIV_HIGH, 16'h0001, 16'hffff);
        rchk("signed_quotient", SEL_MULDIV_LOW, 16'hfffb, 16'hffff);
        @(posedge core_clk);
        md_cmd <= MD_DIVU;
        md_operand <= 16'h0000;
        @(posedge core_clk);
        md_cmd <= MD_IDLE;
        @(negedge core_clk);
        chk("div_zero_flag", 16'h0001, {15'h0000, md_div_zero});
        chk("div_zero_busy", 16'h0000, {15'h0000, md_busy});
        for (k = 0; k < 12; k++) begin
            a = 16'($random(seed));
            b = 16'($random(seed));
            h = 16'($random(seed));
            md(ops[k % 6], h & 16'h007f, a & 16'h3fff, (b & 16'h3fff) | 16'h0100);
        end
        $display("test muldiv done");
        wr(SEL_SYS_CONFIG, 16'h00a5);
        @(negedge core_clk);
        chk("config_before_init", 16'h00a5, system_config);
        @(posedge core_clk);
        end_of_init_instr <= 1'b1;
        @(posedge core_clk);
        end_of_init_instr <= 1'b0;
        wr(SEL_SYS_CONFIG, 16'h005a);
        @(negedge core_clk);
        chk("config_after_init", 16'h00a5, system_config);
        $display("test config done");
        tally_and_finish();
    end
endmodule
